// ---- design/drive_control_word_decoder.sv ----
// Purpose: decode the cyclic drive control word into state and motion commands
// Assumes: telegram slot data arrives synchronous to CLK with a last-item flag
// Notes: control word is taken only on the telegram's last item
// Operation
// - control word sits at one fixed slot
// - apply control word after other telegram data
// - bits 0..3 jointly select state transition
// - host command or internal fault changes state
// - bit meaning depends on operating mode
// - positioning: bit 4 low aborts move
// - speed: bit 4 low disables speed setpoints
// - bit 5 unfreeze ramp or no-stop
// - bit 6 setpoint enable or activate task
// - bit 7 acknowledges latched fault
// - bits 8, 9 switch on jog one, two
// - bit 10 marks PLC control authority
// - bit 11 starts homing run
// - bit 12 relative, bit 13 immediate
// - state reported back through status word
// - positioning: clearing bit 5 decelerates to stop
`timescale 1ns/1ns
`include "cw_consts.svh"
module drive_control_word_decoder
  import cw_pkg::*;
#(
  parameter int SLOT_W = 4,
  parameter logic [SLOT_W-1:0] CW_SLOT = '0
)
(
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  // receive telegram items
  input wire logic RX_VALID,
  input wire logic [SLOT_W-1:0] RX_SLOT,
  input wire logic [`CW_WIDTH-1:0] RX_DATA,
  input wire logic RX_LAST,
  // drive context
  input wire op_mode_t MODE,
  input wire logic FAULT,
  // decoded outputs
  output logic [`CW_WIDTH-1:0] CONTROL_WORD,
  output motion_cmd_t MOTION,
  output logic CMD_STROBE,
  output dev_state_t STATE,
  output logic [`CW_WIDTH-1:0] STATUS_WORD
);
  // ==========================================
  // holding of the control word until the telegram ends
  logic [`CW_WIDTH-1:0] pend_q; // captured word
  logic pend_v_q; // capture seen this telegram
  logic apply_q; // one-cycle apply pulse
  logic [`CW_WIDTH-1:0] cw_q; // applied word
  dev_state_t st;
  logic cw_hit;
  logic end_tel;

  // slot match
  function automatic logic slot_is_cw(input logic v, input logic [SLOT_W-1:0] s);
    slot_is_cw = v && (s == CW_SLOT);
  endfunction : slot_is_cw

  assign cw_hit = slot_is_cw(RX_VALID, RX_SLOT);
  assign end_tel = RX_VALID && RX_LAST;

  // capture the word at its slot, keep until the last item
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      pend_q <= `CW_RESET;
      pend_v_q <= 1'b0;
    end
    else if (CE)
    begin
      if (end_tel)
        pend_v_q <= 1'b0;
      else if (cw_hit)
      begin
        pend_q <= RX_DATA;
        pend_v_q <= 1'b1;
      end
    end
  end

  // apply after all other items of the telegram
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      cw_q <= `CW_RESET;
      apply_q <= 1'b0;
    end
    else if (CE)
    begin
      apply_q <= end_tel && (pend_v_q || cw_hit);
      if (end_tel && cw_hit)
        cw_q <= RX_DATA & ~`CW_RSVD_MASK;
      else if (end_tel && pend_v_q)
        cw_q <= pend_q & ~`CW_RSVD_MASK;
    end
  end

  // ==========================================
  // device state machine
  cw_state_machine u_sm
  (
    .clk(CLK),
    .rstn(RSTN),
    .ce(CE),
    .apply(apply_q),
    .code(cw_q[`CW_SC_MSB:`CW_SC_LSB]),
    .fault_ack(cw_q[`CW_B_FAULT_ACK]),
    .fault_in(FAULT),
    .state_q(st)
  );

  // ==========================================
  // mode-dependent motion decode
  motion_cmd_t mc;
  always_comb
  begin
    mc = '0;
    if (MODE == MODE_POSITION)
    begin
      mc.pos_abort = !cw_q[`CW_B_RAMP];
      mc.pos_no_stop = cw_q[`CW_B_UNFREEZE];
      mc.pos_activate = cw_q[`CW_B_SETPOINT];
    end
    else
    begin
      mc.speed_sp_off = (MODE == MODE_SPEED) && !cw_q[`CW_B_RAMP];
      mc.ramp_unfreeze = cw_q[`CW_B_UNFREEZE];
      mc.sp_enable = cw_q[`CW_B_SETPOINT];
    end
    mc.fault_ack = cw_q[`CW_B_FAULT_ACK];
    mc.jog1 = cw_q[`CW_B_JOG1];
    mc.jog2 = cw_q[`CW_B_JOG2];
    mc.plc_ctrl = cw_q[`CW_B_PLC];
    mc.home_start = cw_q[`CW_B_HOME];
    mc.relative = cw_q[`CW_B_REL];
    mc.immediate = cw_q[`CW_B_IMMED];
  end

  // status word from the current state and the applied PLC bit
  logic [`CW_WIDTH-1:0] sw;
  always_comb
  begin
    sw = '0;
    sw[`SW_BLOCKED] = (st == ST_BLOCKED);
    sw[`SW_RDY_ON] = (st == ST_READY) || (st == ST_SWITCHED_ON) || (st == ST_OP_ENABLED);
    sw[`SW_ON] = (st == ST_SWITCHED_ON) || (st == ST_OP_ENABLED);
    sw[`SW_OP_EN] = (st == ST_OP_ENABLED);
    sw[`SW_FAULT] = (st == ST_FAULT);
    sw[`SW_QSTOP_N] = (st != ST_QUICK_STOP);
    sw[`SW_PLC] = cw_q[`CW_B_PLC];
  end

  // ==========================================
  // registered outputs
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      CONTROL_WORD <= `CW_RESET;
      MOTION <= '0;
      CMD_STROBE <= 1'b0;
      STATE <= ST_BLOCKED;
      STATUS_WORD <= '0;
    end
    else if (CE)
    begin
      CONTROL_WORD <= cw_q;
      MOTION <= mc;
      CMD_STROBE <= apply_q;
      STATE <= st;
      STATUS_WORD <= sw;
    end
  end

  // ==========================================
  // assertions
  sequence last_with_cw_s;
    CE && RX_VALID && RX_LAST && RX_SLOT == CW_SLOT;
  endsequence
  // the word taken at the last item is the applied word one edge later
  apply_after_last_a: assert property (@(posedge CLK) disable iff (!RSTN)
    last_with_cw_s |=> (cw_q == ($past(RX_DATA) & ~`CW_RSVD_MASK)))
    else $error("control word not applied at telegram end");
  // a fresh apply pulse only follows a last item; a frozen pulse is not fresh
  no_early_apply_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (apply_q && $past(CE)) |-> $past(RX_VALID && RX_LAST))
    else $error("apply without telegram end");
  rsvd_zero_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (cw_q & `CW_RSVD_MASK) == 16'h0000)
    else $error("reserved bits nonzero");
  pos_abort_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (MODE == MODE_POSITION) |-> (mc.pos_abort == !cw_q[`CW_B_RAMP]) && !mc.speed_sp_off)
    else $error("positioning abort wrong");
  speed_off_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (MODE == MODE_SPEED && !cw_q[`CW_B_RAMP]) |-> mc.speed_sp_off && !mc.pos_abort)
    else $error("speed setpoints not disabled");
  fault_enter_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && FAULT) |=> (st == ST_FAULT) or !$past(CE))
    else $error("fault did not enter fault state");
  status_track_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && $past(CE) |-> STATUS_WORD[`SW_FAULT] == $past(st == ST_FAULT))
    else $error("status word does not follow state");
  hold_unknown_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && apply_q && !FAULT && st == ST_BLOCKED && cw_q[3:0] != `SC_SHUTDOWN)
    |=> st == ST_BLOCKED)
    else $error("state changed on unmatched code");
  // jog outputs follow the applied word through the output register
  jog_bits_a: assert property (@(posedge CLK) disable iff (!RSTN)
    ($past(CE) && $past(RSTN)) |-> MOTION.jog1 == $past(cw_q[`CW_B_JOG1])
      && MOTION.jog2 == $past(cw_q[`CW_B_JOG2]))
    else $error("jog decode wrong");
endmodule : drive_control_word_decoder

// ---- design/cw_consts.svh ----
// Purpose: constants for the drive control word decoder
// Assumes: 16-bit control word, one word per receive telegram
// Notes: bit positions and state-code values
`ifndef CW_CONSTS_SVH
`define CW_CONSTS_SVH
// ==========================================
// control word layout
`define CW_WIDTH 16
`define CW_RESET 16'h0000
`define CW_SC_LSB 0
`define CW_SC_MSB 3
`define CW_B_RAMP 4
`define CW_B_UNFREEZE 5
`define CW_B_SETPOINT 6
`define CW_B_FAULT_ACK 7
`define CW_B_JOG1 8
`define CW_B_JOG2 9
`define CW_B_PLC 10
`define CW_B_HOME 11
`define CW_B_REL 12
`define CW_B_IMMED 13
`define CW_RSVD_MASK 16'hC000
// ==========================================
// state-control command codes (bits 3..0)
`define SC_SHUTDOWN 4'h6
`define SC_SWITCH_ON 4'h7
`define SC_ENABLE_OP 4'hF
`define SC_DISABLE_V 4'h0
`define SC_QUICK_STOP 4'h2
`define SC_DISABLE_OP 4'h7
// ==========================================
// status word bit positions
`define SW_RDY_ON 0
`define SW_ON 1
`define SW_OP_EN 2
`define SW_FAULT 3
`define SW_QSTOP_N 5
`define SW_BLOCKED 6
`define SW_PLC 9
`endif

// ---- design/cw_pkg.sv ----
// Purpose: types for the drive control word decoder
// Assumes: constants come from cw_consts.svh
// Notes: none
package cw_pkg;
  // ==========================================
  // device states
  typedef enum logic [2:0]
  {
    ST_BLOCKED,
    ST_READY,
    ST_SWITCHED_ON,
    ST_OP_ENABLED,
    ST_QUICK_STOP,
    ST_FAULT
  } dev_state_t;
  // operating modes
  typedef enum logic [1:0]
  {
    MODE_POSITION,
    MODE_SPEED,
    MODE_TORQUE,
    MODE_JOG
  } op_mode_t;
  // decoded motion commands
  typedef struct packed
  {
    logic pos_abort;
    logic pos_no_stop;
    logic pos_activate;
    logic speed_sp_off;
    logic ramp_unfreeze;
    logic sp_enable;
    logic jog1;
    logic jog2;
    logic plc_ctrl;
    logic home_start;
    logic relative;
    logic immediate;
    logic fault_ack;
  } motion_cmd_t;
endpackage : cw_pkg

// ---- design/cw_state_machine.sv ----
// Purpose: device state machine driven by the state-control code
// Assumes: code and strobe are registered by the caller
// Notes: a fault always wins over a host command
`timescale 1ns/1ns
`include "cw_consts.svh"
module cw_state_machine
  import cw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // command
  input wire logic apply,
  input wire logic [3:0] code,
  input wire logic fault_ack,
  input wire logic fault_in,
  // state
  output dev_state_t state_q
);
  dev_state_t state_d;
  // ==========================================
  // next-state decode of the joint four-bit code
  always_comb
  begin
    state_d = state_q;
    if (fault_in)
      state_d = ST_FAULT;
    else if (apply)
    begin
      case (state_q)
        ST_BLOCKED:
          if (code == `SC_SHUTDOWN) state_d = ST_READY;
        ST_READY:
          if (code == `SC_SWITCH_ON) state_d = ST_SWITCHED_ON;
          else if (code[1] == 1'b0) state_d = ST_BLOCKED;
        ST_SWITCHED_ON:
          if (code == `SC_ENABLE_OP) state_d = ST_OP_ENABLED;
          else if (code == `SC_SHUTDOWN) state_d = ST_READY;
          else if (code[1] == 1'b0) state_d = ST_BLOCKED;
        ST_OP_ENABLED:
          if (code == `SC_DISABLE_OP) state_d = ST_SWITCHED_ON;
          else if (code == `SC_SHUTDOWN) state_d = ST_READY;
          else if (code == `SC_QUICK_STOP) state_d = ST_QUICK_STOP;
          else if (code[1] == 1'b0) state_d = ST_BLOCKED;
        ST_QUICK_STOP:
          if (code[1] == 1'b0) state_d = ST_BLOCKED;
        ST_FAULT:
          if (fault_ack) state_d = ST_BLOCKED;
        default:
          state_d = state_q;
      endcase
    end
  end
  // state register
  always_ff @(posedge clk)
  begin
    if (!rstn)
      state_q <= ST_BLOCKED;
    else if (ce)
      state_q <= state_d;
  end
endmodule : cw_state_machine

// ---- bench/cw_master.sv ----
// Purpose: fieldbus master model sending cyclic receive telegrams
// Assumes: slot 0 holds the control word, slot 1 a setpoint
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ns
module cw_master
#(
  parameter int SLOT_W = 4
)
(
  // clock
  input wire logic clk,
  // telegram item lines
  output logic rx_valid,
  output logic [SLOT_W-1:0] rx_slot,
  output logic [15:0] rx_data,
  output logic rx_last
);
  // ==========================================
  // idle lines at time zero
  initial
  begin
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_slot = '0;
    rx_data = 16'h0000;
  end
  // ==========================================
  // one telegram: control word item, then setpoint as last item
  task automatic send(input logic [15:0] cw, input logic with_cw);
    begin
      @(negedge clk);
      if (with_cw)
      begin
        rx_valid = 1'b1;
        rx_slot = SLOT_W'(0);
        rx_data = cw;
        @(negedge clk);
      end
      // setpoint closes the telegram
      rx_valid = 1'b1;
      rx_slot = SLOT_W'(1);
      rx_data = 16'h1234;
      rx_last = 1'b1;
      @(negedge clk);
      // release: lines no longer hold the last value
      rx_valid = 1'b0;
      rx_last = 1'b0;
      rx_slot = ~rx_slot;
      rx_data = ~rx_data;
    end
  endtask : send
endmodule : cw_master

// ---- bench/drive_control_word_decoder_test.sv ----
// Purpose: self-checking bench for the control word decoder
// Assumes: master model drives telegrams on falling edges
// Notes: table rows cover mode bits, hand tests follow
`timescale 1ns/1ns
module drive_control_word_decoder_test
  import cw_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic fault = 1'b0;
  op_mode_t mode = MODE_POSITION;
  logic rx_valid, rx_last, strobe;
  logic [3:0] rx_slot;
  logic [15:0] rx_data, cw, sw;
  motion_cmd_t motion;
  dev_state_t state;
  int err_total = 0;
  int tests_run = 0;
  // rows: mode, word, expected motion
  op_mode_t rm [8] = '{MODE_POSITION, MODE_POSITION, MODE_SPEED, MODE_SPEED,
    MODE_POSITION, MODE_SPEED, MODE_TORQUE, MODE_JOG};
  logic [15:0] rw [8] = '{16'h0000, 16'h0070, 16'h0000, 16'h0070, 16'h0F80, 16'h3100,
    16'h0060, 16'h0040};
  logic [12:0] rx [8] = '{13'h1000, 13'h0C00, 13'h0200, 13'h0180, 13'h1079, 13'h0246,
    13'h0180, 13'h0080};
  // ==========================================
  // clock and instances
  always #50 clk = ~clk;
  cw_master i_master (.clk(clk), .rx_valid(rx_valid), .rx_slot(rx_slot),
    .rx_data(rx_data), .rx_last(rx_last));
  drive_control_word_decoder i_dut (.CLK(clk), .RSTN(rstn), .CE(ce), .RX_VALID(rx_valid),
    .RX_SLOT(rx_slot), .RX_DATA(rx_data), .RX_LAST(rx_last), .MODE(mode), .FAULT(fault),
    .CONTROL_WORD(cw), .MOTION(motion), .CMD_STROBE(strobe), .STATE(state),
    .STATUS_WORD(sw));
  // ==========================================
  // compare, verdict, telegram helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    begin
      tests_run++;
      if (g !== e)
      begin
        err_total++;
        $display("ERROR %s expected %h seen %h", nm, e, g);
      end
    end
  endtask : chk
  task automatic results();
    begin
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask : results
  // send a word and wait, bounded, for the applied strobe
  task automatic tele(input logic [15:0] w);
    int n;
    begin
      i_master.send(w, 1'b1);
      n = 0;
      while (strobe !== 1'b1 && n < 8)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("strobe", 16'h0001, {15'h0, strobe});
      if (strobe !== 1'b1)
        results();
    end
  endtask : tele
  // state one edge after the strobe
  task automatic st(input dev_state_t e);
    begin
      @(posedge clk);
      #1;
      chk("state", {13'h0, e}, {13'h0, state});
    end
  endtask : st
  // ==========================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    chk("rst_state", 16'h0000, {13'h0, state});
    chk("rst_cw", 16'h0000, cw);
    @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("rst_status", 16'h0060, sw);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk);
      mode = rm[i];
      tele(rw[i]);
      chk("cw", rw[i], cw);
      chk("motion", {3'h0, rx[i]}, {3'h0, motion});
    end
    $display("table test done");
    tele(16'h0006);
    st(ST_READY);
    chk("status", 16'h0021, sw);
    tele(16'h0007);
    st(ST_SWITCHED_ON);
    tele(16'h000F);
    st(ST_OP_ENABLED);
    tele(16'h000B);
    st(ST_OP_ENABLED);
    tele(16'hC40F);
    chk("rsvd_cw", 16'h040F, cw);
    $display("state test done");
    i_master.send(16'h0000, 1'b0);
    repeat (5)
    begin
      @(posedge clk);
      #1;
      chk("no_slot", 16'h0000, {15'h0, strobe});
    end
    @(negedge clk);
    fault = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("fault_state", {13'h0, ST_FAULT}, {13'h0, state});
    chk("fault_status", 16'h0228, sw);
    @(negedge clk);
    fault = 1'b0;
    tele(16'h0080);
    st(ST_BLOCKED);
    $display("fault test done");
    // enable low: a whole telegram passes unseen
    @(negedge clk);
    ce = 1'b0;
    i_master.send(16'h0006, 1'b1);
    repeat (3)
    begin
      @(posedge clk);
      #1;
      chk("ce_strobe", 16'h0000, {15'h0, strobe});
    end
    chk("ce_cw", 16'h0080, cw);
    @(negedge clk);
    ce = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("ce_state", {13'h0, ST_BLOCKED}, {13'h0, state});
    $display("enable test done");
    results();
  end
endmodule : drive_control_word_decoder_test
